// ### oc_pkg.sv
// Purpose: Shared constants and types for the over-current fault response sequencer
// Assumes: One 100 MHz clock; the action byte is written through a plain byte write port
// Notes:   Field positions follow the action byte layout
// Contract
// R01: Code 10 keeps running current limited for the programmed delay.
// R02: Code 10 still limiting when delay ends shuts down, then applies retry policy.
// R03: Code 11 shuts output down at once, then applies retry policy.
// R04: Three-bit retry field sets how many restart attempts follow a shutdown.
// R05: Retry field zero means no restart; output stays off until fault cleared.
// R06: Retry values one to four give that many attempts, then latch off.
// R07: Retry field all ones restarts without limit.
// R08: Attempt start-to-start interval is delay count times the time unit; the code takes one clock more.
// R09: Fault during an attempt fails it; attempt count reloads per fault sequence.
// R10: Every code sets the over-current status flag and notifies the host.
// R11: Code 00 current limits forever and never shuts down.
// R12: Code 01 limits while voltage above threshold; below it shuts down and retries.
// R13: Delay field n selects two to the n time units, one to 128.
`default_nettype none
package oc_pkg;
  // ==========================================================================
  // Action byte layout
  localparam int ACTION_W   = 8;
  localparam int RESP_MSB   = 7;
  localparam int RESP_LSB   = 6;
  localparam int RETRY_MSB  = 5;
  localparam int RETRY_LSB  = 3;
  localparam int DELAY_MSB  = 2;
  localparam int DELAY_LSB  = 0;
  localparam int RETRY_W    = RETRY_MSB - RETRY_LSB + 1;
  localparam int DELAY_W    = DELAY_MSB - DELAY_LSB + 1;
  localparam logic [ACTION_W-1:0] ACTION_RESET = 8'hc0;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_COND_CC = 2'h1;
  localparam logic [1:0] RESP_DELAY   = 2'h2;
  localparam logic [1:0] RESP_DISABLE = 2'h3;
  localparam logic [RETRY_W-1:0] RETRY_NONE    = 3'h0;
  localparam logic [RETRY_W-1:0] RETRY_FOREVER = 3'h7;

  // ==========================================================================
  // Time base: unit length in clock cycles, unit multiplier up to 128
  localparam int UNIT_W  = 16;
  localparam int UNITS_W = 8;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LIMIT,
    ST_WAIT,
    ST_RETRY,
    ST_LATCHED
  } seq_state_e;
endpackage
`default_nettype wire

// ### timer_if.sv
// Purpose: Carries delay-timer requests between sequencer and timer
// Assumes: Single clock domain
// Notes:   done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
  import oc_pkg::*;
  logic                start;
  logic [DELAY_W-1:0]  delay_code;
  logic [UNIT_W-1:0]   unit_cycles;
  logic                done;
  modport ctrl (output start, output delay_code, output unit_cycles, input done);
  modport tmr  (input start, input delay_code, input unit_cycles, output done);
endinterface
`default_nettype wire

// ### delay_unit_timer.sv
// Purpose: Counts two-to-the-n time units after a start pulse
// Assumes: unit_cycles of zero is treated as one cycle
// Notes:   A new start restarts the count; done pulses once per count that runs to the end, none for a restarted one
`timescale 1ns/1ps
`default_nettype none
module delay_unit_timer (
  input  wire logic clk,
  input  wire logic rst_b,
  timer_if.tmr      tif
);
  import oc_pkg::*;

  typedef struct packed {
    logic               active;
    logic               done;
    logic [UNIT_W-1:0]  div;
    logic [UNITS_W-1:0] units;
  } tmr_s;

  localparam tmr_s TMR_RESET = '{active: 1'b0, done: 1'b0, div: '0, units: '0};

  tmr_s              q;
  tmr_s              d;
  logic [UNIT_W-1:0] reload;

  // ==========================================================================
  // Unit divider and unit counter
  always_comb begin
    reload = (tif.unit_cycles == '0) ? '0 : tif.unit_cycles - UNIT_W'(1);
    d      = q;
    d.done = 1'b0;
    if (tif.start) begin
      d.active = 1'b1;
      d.div    = reload;
      d.units  = UNITS_W'(1) << tif.delay_code; // R13
    end else if (q.active) begin
      if (q.div == '0) begin
        d.div = reload;
        if (q.units == UNITS_W'(1)) begin
          d.active = 1'b0;
          d.done   = 1'b1;
        end else begin
          d.units = q.units - UNITS_W'(1);
        end
      end else begin
        d.div = q.div - UNIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= TMR_RESET;
    end else begin
      q <= d;
    end
  end

  assign tif.done = q.done;
endmodule
`default_nettype wire

// ### overcurrent_fault_retry_sequencer.sv
// Purpose: Over-current fault response and restart-retry sequencer
// Assumes: Fault and voltage inputs are synchronous; time unit comes from elsewhere
// Notes:   Output enable and limit indication decode the registered state
`timescale 1ns/1ps
`default_nettype none
module overcurrent_fault_retry_sequencer (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          cfg_wr_en,
  input  wire logic [oc_pkg::ACTION_W-1:0]   cfg_wr_data,
  output logic      [oc_pkg::ACTION_W-1:0]   cfg_rd_data,
  input  wire logic [oc_pkg::UNIT_W-1:0]     time_unit_cycles,
  input  wire logic                          oc_fault,
  input  wire logic                          vout_below_lv,
  input  wire logic                          fault_clear,
  output logic                               output_enable,
  output logic                               current_limit_active,
  output logic                               oc_fault_flag,
  output logic                               host_alert,
  output logic      [oc_pkg::RETRY_W-1:0]    retries_left
);
  import oc_pkg::*;

  typedef struct packed {
    seq_state_e          st;
    logic [RETRY_W-1:0]  remaining;
    logic                flag;
    logic [ACTION_W-1:0] cfg;
  } seq_s;

  localparam seq_s SEQ_RESET = '{st: ST_RUN, remaining: '0, flag: 1'b0, cfg: ACTION_RESET};

  seq_s               q;
  seq_s               d;
  logic               start_c;
  logic               go_off;
  logic [1:0]         resp;
  logic [RETRY_W-1:0] retry;

  timer_if tif ();

  delay_unit_timer u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .tif   (tif)
  );

  assign resp            = q.cfg[RESP_MSB:RESP_LSB];
  assign retry           = q.cfg[RETRY_MSB:RETRY_LSB];
  assign tif.start       = start_c;
  assign tif.delay_code  = q.cfg[DELAY_MSB:DELAY_LSB]; // R08
  assign tif.unit_cycles = time_unit_cycles;

  // ==========================================================================
  // Sequencer
  always_comb begin
    d       = q;
    start_c = 1'b0;
    go_off  = 1'b0;
    if (cfg_wr_en) begin
      d.cfg = cfg_wr_data;
    end
    // Set beats clear so a fault landing on the clear cycle in ST_RUN is not lost
    if (fault_clear) begin
      d.flag = 1'b0;
    end
    if (oc_fault && q.st == ST_RUN) begin
      d.flag = 1'b1; // R10
    end
    case (q.st)
      ST_RUN: begin
        if (oc_fault) begin
          d.remaining = retry; // R09
          if (resp == RESP_DISABLE) begin
            go_off = 1'b1; // R03
          end else begin
            d.st    = ST_LIMIT; // R11
            start_c = (resp == RESP_DELAY); // R01
          end
        end
      end
      ST_LIMIT: begin
        if (!oc_fault) begin
          d.st = ST_RUN;
        end else if (resp == RESP_COND_CC && vout_below_lv) begin
          go_off = 1'b1; // R12
        end else if (resp == RESP_DELAY && tif.done) begin
          go_off = 1'b1; // R02
        end
      end
      ST_WAIT: begin
        if (tif.done) begin
          d.st    = ST_RETRY;
          start_c = 1'b1; // R08
          if (retry != RETRY_FOREVER) begin
            d.remaining = q.remaining - RETRY_W'(1); // R04
          end
        end
      end
      ST_RETRY: begin
        if (oc_fault) begin
          if (q.remaining == RETRY_NONE && retry != RETRY_FOREVER) begin
            d.st = ST_LATCHED; // R06
          end else begin
            d.st    = ST_WAIT; // R07
            start_c = tif.done;
          end
        end else if (tif.done) begin
          d.st = ST_RUN;
        end
      end
      ST_LATCHED: begin
        if (fault_clear) begin
          d.st = ST_RUN;
        end
      end
      default: begin
        d.st = ST_LATCHED;
      end
    endcase
    if (go_off) begin
      if (retry == RETRY_NONE) begin
        d.st = ST_LATCHED; // R05
      end else begin
        // Off interval counts before the first attempt too
        d.st    = ST_WAIT;
        start_c = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= SEQ_RESET;
    end else begin
      q <= d;
    end
  end

  assign output_enable        = (q.st == ST_RUN) || (q.st == ST_LIMIT) || (q.st == ST_RETRY);
  assign current_limit_active = (q.st == ST_LIMIT);
  assign oc_fault_flag        = q.flag;
  assign host_alert           = q.flag; // R10
  assign retries_left         = q.remaining;
  assign cfg_rd_data          = q.cfg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_fault_in_run;
    q.st == ST_RUN && oc_fault && !cfg_wr_en;
  endsequence

  sequence s_limit_fault;
    q.st == ST_LIMIT && oc_fault && !cfg_wr_en;
  endsequence

  property p_disable_now;
    s_fault_in_run and (resp == RESP_DISABLE) |=> !output_enable;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("Code 11 did not shut down"); // R03

  property p_ignore_limits;
    s_fault_in_run and (resp == RESP_IGNORE) ##1 s_limit_fault [*2] |=> current_limit_active && output_enable;
  endproperty
  a_ignore_limits: assert property (p_ignore_limits) else $error("Code 00 left limiting"); // R11

  property p_cond_shutdown;
    s_limit_fault and (resp == RESP_COND_CC) && vout_below_lv |=> !output_enable;
  endproperty
  a_cond_shutdown: assert property (p_cond_shutdown) else $error("Code 01 kept running below threshold"); // R12

  property p_delay_runs;
    s_limit_fault and (resp == RESP_DELAY) && !tif.done && !vout_below_lv |=> output_enable;
  endproperty
  a_delay_runs: assert property (p_delay_runs) else $error("Code 10 stopped before delay end"); // R01

  property p_delay_expiry;
    s_limit_fault and (resp == RESP_DELAY) && tif.done |=> !output_enable;
  endproperty
  a_delay_expiry: assert property (p_delay_expiry) else $error("Code 10 still on after delay"); // R02

  property p_no_retry;
    s_fault_in_run and (resp == RESP_DISABLE) && (retry == RETRY_NONE) |=> q.st == ST_LATCHED;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("Restart attempted with zero retries"); // R05

  property p_latched_holds;
    q.st == ST_LATCHED && !fault_clear |=> !output_enable && q.st == ST_LATCHED;
  endproperty
  a_latched_holds: assert property (p_latched_holds) else $error("Latched output came back"); // R06

  property p_attempt_fail;
    q.st == ST_RETRY && oc_fault |=> !output_enable;
  endproperty
  a_attempt_fail: assert property (p_attempt_fail) else $error("Failed attempt kept output on"); // R09

  property p_forever;
    q.st == ST_RETRY && oc_fault && retry == RETRY_FOREVER && !cfg_wr_en |=> q.st == ST_WAIT;
  endproperty
  a_forever: assert property (p_forever) else $error("Continuous retry gave up"); // R07

  property p_count_down;
    q.st == ST_WAIT && tif.done && retry != RETRY_FOREVER && !cfg_wr_en
      |=> retries_left == $past(q.remaining) - RETRY_W'(1);
  endproperty
  a_count_down: assert property (p_count_down) else $error("Attempt count not decremented"); // R04

  property p_flag_set;
    s_fault_in_run |=> oc_fault_flag && host_alert;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Fault flag not set"); // R10

  property p_reload;
    s_fault_in_run |=> retries_left == $past(retry);
  endproperty
  a_reload: assert property (p_reload) else $error("Attempt count not reloaded on new fault"); // R09

  property p_attempt_start;
    q.st == ST_WAIT && tif.done |=> q.st == ST_RETRY && output_enable;
  endproperty
  a_attempt_start: assert property (p_attempt_start) else $error("Attempt did not start at interval end"); // R08

  property p_clear_release;
    q.st == ST_LATCHED && fault_clear |=> q.st == ST_RUN && output_enable;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("Clear did not release latched output"); // R05
endmodule
`default_nettype wire

// ### oc_host_model.sv
// Purpose: Host model that writes the fault action byte
// Assumes: Writes are launched on the falling clock edge
// Notes:   One strobe cycle per byte; data is scrambled once released
`timescale 1ns/1ps
`default_nettype none
module oc_host_model (
  input  wire logic                        clk,
  output logic                             cfg_wr_en,
  output logic [oc_pkg::ACTION_W-1:0]      cfg_wr_data
);
  initial begin
    cfg_wr_en   = 1'b0;
    cfg_wr_data = 8'h00;
  end
  // Strobe stands one full cycle, so exactly one rising edge takes it
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    cfg_wr_en   <= 1'b1;
    cfg_wr_data <= b;
    @(negedge clk);
    cfg_wr_en   <= 1'b0;
    cfg_wr_data <= ~b;
  endtask
endmodule
`default_nettype wire

// ### overcurrent_fault_retry_sequencer_test.sv
// Purpose: Self-checking bench for the over-current retry sequencer
// Assumes: Inputs change on the falling edge; small time units
// Notes:   Results are noted in a queue and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module overcurrent_fault_retry_sequencer_test;
  import oc_pkg::*;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                oc_fault = 1'b0;
  logic                vout_lv = 1'b0;
  logic                fault_clear = 1'b0;
  logic [UNIT_W-1:0]   unit = 16'h0001;
  logic                cfg_wr_en;
  logic [ACTION_W-1:0] cfg_wr_data;
  logic [ACTION_W-1:0] rd;
  logic                oe, lim, flag, alert;
  logic [RETRY_W-1:0]  left;
  logic [15:0]         exp_q[$];
  logic [15:0]         act_v;
  logic [31:0]         rng = 32'd22;
  int                  fails = 0;
  int                  comparisons = 0;
  event                got;
  wire  [6:0]          st = {oe, lim, flag, alert, left};

  always #5 clk = ~clk;

  oc_host_model i_host (.clk(clk), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data));

  overcurrent_fault_retry_sequencer i_dut (
    .clk(clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(rd), .time_unit_cycles(unit), .oc_fault(oc_fault),
    .vout_below_lv(vout_lv), .fault_clear(fault_clear), .output_enable(oe),
    .current_limit_active(lim), .oc_fault_flag(flag), .host_alert(alert),
    .retries_left(left));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    exp_q.push_back(e);
    act_v = a;
    -> got;
    #1;
  endtask

  task automatic clr();
    fault_clear = 1'b1;
    cyc(1);
    fault_clear = 1'b0;
  endtask

  always @(got) begin
    logic [15:0] e;
    e = exp_q.pop_front();
    comparisons++;
    if (act_v !== e) begin
      fails++;
      $display("[FAIL] %0t exp=%h act=%h", $time, e, act_v);
    end
  end

  task automatic test_done();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: whole sequence needs a few thousand cycles
  initial begin
    #200000;
    fails++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] b;
    logic [2:0] rv;
    logic [2:0] tn;
    int t, rises, gap, last, k;
    logic prev;
    cyc(16);
    rst_b = 1'b1;
    cyc(1);
    chk({8'h00, 1'b0, 7'h40}, {8'h00, 1'b0, st});
    chk({8'h00, ACTION_RESET}, {8'h00, rd});
    b = 8'(xs());
    i_host.put(b);
    chk({8'h00, b}, {8'h00, rd});
    unit = 16'(xs() % 4 + 1);
    tn = 3'(xs() % 3);
    t = int'(unit) * (1 << tn);
    // Sweep every retry setting, the three above four as well
    for (int r = 0; r < 8; r++) begin
      rv = 3'(r);
      i_host.put({RESP_DISABLE, rv, tn});
      oc_fault = 1'b1;
      cyc(1);
      chk({9'h0, 4'b0011, rv}, {9'h0, st});
      rises = 0;
      gap = 0;
      last = 0;
      for (k = 1; k <= 300; k++) begin
        prev = oe;
        cyc(1);
        if (oe && !prev) begin
          if (rises > 0) gap = k - last;
          last = k;
          rises++;
        end
      end
      if (rv == RETRY_FOREVER) begin
        chk(16'h1, {15'h0, rises > 4});
        chk(16'(t + 1), 16'(gap));
      end else begin
        chk(16'(rv), 16'(rises));
      end
      oc_fault = 1'b0;
      cyc(2 * t + 6);
      chk({15'h0, rv == RETRY_FOREVER}, {15'h0, oe});
      clr();
      chk(16'h2, {14'h0, oe, flag});
    end
    i_host.put({RESP_IGNORE, 3'h1, tn});
    oc_fault = 1'b1;
    cyc(60);
    chk(16'h7, {13'h0, oe, lim, flag});
    oc_fault = 1'b0;
    cyc(1);
    chk(16'h5, {13'h0, oe, lim, flag});
    clr();
    i_host.put({RESP_COND_CC, 3'h0, tn});
    oc_fault = 1'b1;
    cyc(20);
    chk(16'h3, {14'h0, oe, lim});
    vout_lv = 1'b1;
    cyc(1);
    chk(16'h0, {14'h0, oe, lim});
    oc_fault = 1'b0;
    vout_lv = 1'b0;
    clr();
    i_host.put({RESP_DELAY, 3'h0, tn});
    oc_fault = 1'b1;
    cyc(1);
    chk(16'h3, {14'h0, oe, lim});
    for (k = 1; k < 200 && oe; k++)
      cyc(1);
    chk(16'(t + 2), 16'(k));
    oc_fault = 1'b0;
    clr();
    oc_fault = 1'b1;
    cyc(1);
    oc_fault = 1'b0;
    cyc(2 * t + 4);
    chk(16'h2, {14'h0, oe, lim});
    test_done();
  end
endmodule
`default_nettype wire
